// file: design/power_control_and_reset.sv
// Power control register and reset sequencer of the microcontroller
`timescale 1ns/1ps

module power_control_and_reset #(
   parameter int OSC_DIV = pwr_rst_pkg::OSC_PER_MACHINE_CYCLE
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic reset_pin_in,
   input wire logic watchdog_enable_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_bit_op_in,
   input wire logic [1:0] serial_mode_in,
   input wire logic wdt_load_req_in,
   input wire logic wdt_overflow_in,
   input wire logic irq_pending_in,
   input wire logic ale_raw_in,
   input wire logic program_store_strobe_raw_in,
   output logic [7:0] sfr_rdata_out,
   output logic baud_x2_out,
   output logic wdt_load_out,
   output logic idle_out,
   output logic powerdown_out,
   output logic osc_run_out,
   output logic timer2_reset_out,
   output logic pwm_force_high_out,
   output logic adc_abort_out,
   output logic reset_pin_pull_out,
   output logic reset_pin_pull_oe_out,
   output logic internal_reset_out,
   output logic address_latch_strobe_out,
   output logic program_store_strobe_out,
   output logic [7:0] port_reset_value_out,
   output logic [7:0] stack_ptr_reset_out,
   output logic [7:0] set_enable_reset_out
);

   // -----------------------------------------------
   // Machine cycle enable
   // -----------------------------------------------
   // Pulse counted in clocks so its length never depends on divider phase
   localparam int WDT_CLKS = pwr_rst_pkg::WDT_PULSE_MC * OSC_DIV;
   localparam int WDT_W = $clog2(WDT_CLKS + 1);
   logic [3:0] osc_cnt;
   logic mc_tick;
   logic baud_double;
   logic ale_quiet;
   logic wdt_load_enable;
   logic user_flag_1;
   logic user_flag_0;
   logic powerdown_bit;
   logic idle_bit;
   logic rst_seen;
   logic internal_reset;
   logic [WDT_W-1:0] wdt_cnt;
   logic wdt_pulse;
   logic reg_wr;
   logic wdt_load_ok;

   // Oscillator halts in power-down, so the divider is held at zero too
   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         osc_cnt <= 4'h0;
      else if (powerdown_bit)
         osc_cnt <= 4'h0;
      else if (osc_cnt == 4'(OSC_DIV - 1))
         osc_cnt <= 4'h0;
      else
         osc_cnt <= osc_cnt + 4'h1;
   end

   assign mc_tick = !powerdown_bit && (osc_cnt == 4'(OSC_DIV - 1));

   // -----------------------------------------------
   // Watchdog pulse on the reset line
   // -----------------------------------------------
   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         wdt_cnt <= WDT_W'(0);
      else if (wdt_overflow_in)
         wdt_cnt <= WDT_W'(WDT_CLKS);
      else if (!powerdown_bit && wdt_cnt != WDT_W'(0))
         wdt_cnt <= wdt_cnt - WDT_W'(1);
   end

   assign wdt_pulse = (wdt_cnt != WDT_W'(0));
   assign reset_pin_pull_out = wdt_pulse;
   assign reset_pin_pull_oe_out = wdt_pulse;

   // -----------------------------------------------
   // Reset sampling
   // -----------------------------------------------
   // Internal path keeps the watchdog effective with the pin tied low
   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         rst_seen <= 1'b0;
         internal_reset <= 1'b1;
      end
      else if (powerdown_bit)
      begin
         // Pin still watched: reset is the only way out
         // A lone high glitch must not linger in rst_seen
         rst_seen <= reset_pin_in;
         internal_reset <= rst_seen && reset_pin_in;
      end
      else if (mc_tick)
      begin
         rst_seen <= reset_pin_in || wdt_pulse;
         internal_reset <= rst_seen && (reset_pin_in || wdt_pulse);
      end
   end

   assign internal_reset_out = internal_reset;

   // -----------------------------------------------
   // Power control register
   // -----------------------------------------------
   // Bit operations never hit this register
   assign reg_wr = sfr_wr_in && !sfr_bit_op_in &&
      (sfr_addr_in == pwr_rst_pkg::POWER_CONTROL_ADDR);
   assign wdt_load_ok = wdt_load_req_in && wdt_load_enable;

   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         baud_double <= 1'b0;
         ale_quiet <= 1'b0;
         user_flag_1 <= 1'b0;
         user_flag_0 <= 1'b0;
      end
      else if (internal_reset)
      begin
         baud_double <= pwr_rst_pkg::POWER_CONTROL_RESET[7];
         ale_quiet <= pwr_rst_pkg::POWER_CONTROL_RESET[5];
         user_flag_1 <= pwr_rst_pkg::POWER_CONTROL_RESET[3];
         user_flag_0 <= pwr_rst_pkg::POWER_CONTROL_RESET[2];
      end
      else if (reg_wr) // Bit 6 not stored
      begin
         baud_double <= sfr_wdata_in[pwr_rst_pkg::BAUD_DOUBLE_POS];
         ale_quiet <= sfr_wdata_in[pwr_rst_pkg::ALE_QUIET_POS];
         user_flag_1 <= sfr_wdata_in[pwr_rst_pkg::USER_FLAG_1_POS];
         user_flag_0 <= sfr_wdata_in[pwr_rst_pkg::USER_FLAG_0_POS];
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         wdt_load_enable <= 1'b0;
      else if (internal_reset)
         wdt_load_enable <= 1'b0;
      else if (wdt_load_ok)
         wdt_load_enable <= 1'b0;
      else if (reg_wr)
         wdt_load_enable <= sfr_wdata_in[pwr_rst_pkg::WDT_LOAD_ENABLE_POS];
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         powerdown_bit <= 1'b0;
      else if (internal_reset)
         powerdown_bit <= 1'b0;
      else if (reg_wr && sfr_wdata_in[pwr_rst_pkg::POWERDOWN_POS] &&
               watchdog_enable_n_in)
         powerdown_bit <= 1'b1;
   end

   // Idle only when power-down was not granted by the same write
   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         idle_bit <= 1'b0;
      else if (internal_reset)
         idle_bit <= 1'b0;
      else if (irq_pending_in)
         idle_bit <= 1'b0;
      else if (reg_wr && sfr_wdata_in[pwr_rst_pkg::IDLE_POS])
         idle_bit <= !(sfr_wdata_in[pwr_rst_pkg::POWERDOWN_POS] &&
                       watchdog_enable_n_in);
   end

   // Reserved bit reads zero
   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         sfr_rdata_out <= 8'h00;
      else
         sfr_rdata_out <= {baud_double, 1'b0, ale_quiet, wdt_load_enable,
            user_flag_1, user_flag_0, powerdown_bit, idle_bit};
   end

   // -----------------------------------------------
   // Mode outputs
   // -----------------------------------------------
   assign baud_x2_out = baud_double && (serial_mode_in != 2'h0);
   assign wdt_load_out = wdt_load_ok;
   assign idle_out = idle_bit;
   assign powerdown_out = powerdown_bit;
   assign osc_run_out = !powerdown_bit;
   assign timer2_reset_out = idle_bit;
   assign pwm_force_high_out = idle_bit;
   assign adc_abort_out = idle_bit;

   // Strobes high in reset and idle; low when the oscillator stops
   assign address_latch_strobe_out = internal_reset ? 1'b1 :
      (powerdown_bit ? 1'b0 :
      ((idle_bit || ale_quiet) ? 1'b1 : ale_raw_in));
   assign program_store_strobe_out = internal_reset ? 1'b1 :
      (powerdown_bit ? 1'b0 : (idle_bit ? 1'b1 : program_store_strobe_raw_in));

   // RAM has no reset path here at all
   assign port_reset_value_out = pwr_rst_pkg::PORT_RESET;
   assign stack_ptr_reset_out = pwr_rst_pkg::STACK_PTR_RESET;
   assign set_enable_reset_out = pwr_rst_pkg::SET_ENABLE_RESET;

   // -----------------------------------------------
   // Checks
   // -----------------------------------------------
   strobes_in_reset_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      internal_reset |-> address_latch_strobe_out && program_store_strobe_out)
      else $error("strobes not high in reset");

   ale_quiet_hold_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      ale_quiet && !powerdown_bit && !internal_reset
         |-> address_latch_strobe_out)
      else $error("address strobe toggled while quiet");

   wdt_load_gate_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      wdt_load_out |=> !wdt_load_enable)
      else $error("load enable not cleared after load");

   wdt_load_block_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      !wdt_load_enable |-> !wdt_load_out)
      else $error("load accepted without enable");

   pd_needs_enable_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(powerdown_bit) |-> $past(watchdog_enable_n_in) && $past(reg_wr))
      else $error("power-down set without enable high");

   pd_over_idle_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      reg_wr && !internal_reset && sfr_wdata_in[1] && sfr_wdata_in[0]
         && watchdog_enable_n_in && !irq_pending_in
         |=> powerdown_bit && !idle_bit)
      else $error("idle entered despite power-down");

   irq_ends_idle_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      irq_pending_in |=> !idle_bit)
      else $error("interrupt did not clear idle");

   sequence two_high_s;
      mc_tick && rst_seen && reset_pin_in;
   endsequence

   reset_second_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      two_high_s |=> internal_reset)
      else $error("no reset on second high sample");

   wdt_pulse_len_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(wdt_pulse) && !wdt_overflow_in ##1 !wdt_overflow_in [*1]
         |-> wdt_pulse)
      else $error("watchdog pulse ended early");

   reset_clears_a: assert property (
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      internal_reset |=> !idle_bit && !powerdown_bit && !ale_quiet)
      else $error("reset left control bits set");

endmodule // power_control_and_reset

// file: design/pwr_rst_pkg.sv
// Package: constants for power control and reset sequencing
package pwr_rst_pkg;
   // -----------------------------------------------
   // Register map
   // -----------------------------------------------
   localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam int BAUD_DOUBLE_POS = 7;
   localparam int RESERVED_POS = 6;
   localparam int ALE_QUIET_POS = 5;
   localparam int WDT_LOAD_ENABLE_POS = 4;
   localparam int USER_FLAG_1_POS = 3;
   localparam int USER_FLAG_0_POS = 2;
   localparam int POWERDOWN_POS = 1;
   localparam int IDLE_POS = 0;
   // -----------------------------------------------
   // Timing
   // -----------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int OSC_PER_MACHINE_CYCLE = 12;
   localparam int MIN_RESET_US = 2;
   localparam int MIN_RESET_MC = 2;
   localparam int MIN_RESET_CLKS =
      (MIN_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDT_PULSE_MC = 3;
   // -----------------------------------------------
   // Reset values of neighbouring registers
   // -----------------------------------------------
   localparam logic [7:0] PORT_RESET = 8'hFF;
   localparam logic [7:0] STACK_PTR_RESET = 8'h07;
   localparam logic [7:0] SET_ENABLE_RESET = 8'hC0;
endpackage

// file: tb/reset_source.sv
// Model of the external reset source that drives the reset pin
`timescale 1ns/1ps
module reset_source (
   input wire logic pull_in,
   input wire logic pull_oe_in,
   output logic pin_out
);
   // ------------------------------
   // Pin level
   // ------------------------------
   logic ext_high;
   initial ext_high = 1'b0;
   // Pin has a pull-down to ground, so a released line reads low
   assign pin_out = ext_high | (pull_oe_in & pull_in);
   // Caller holds high long enough for a full reset
   task drive(input logic v);
      ext_high = v;
   endtask
endmodule // reset_source

// file: tb/tb.sv
// Self-checking bench for the power control and reset block
`timescale 1ns/1ps
module tb;
   // ------------------------------
   // Signals
   // ------------------------------
   localparam int DIV = 2;
   localparam int HOLD = (pwr_rst_pkg::MIN_RESET_CLKS > 2 * DIV) ?
      pwr_rst_pkg::MIN_RESET_CLKS : 2 * DIV;
   localparam logic [7:0] A = pwr_rst_pkg::POWER_CONTROL_ADDR;
   logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, reset_pin_in;
   logic ew = 1'b1, wr = 1'b0, bop = 1'b0, ldreq = 1'b0, ovf = 1'b0;
   logic irq = 1'b0, ale = 1'b0, program_store_strobe = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   logic [1:0] mode = 2'h0;
   logic [7:0] rdata, portv, spv, stev;
   logic baud, ld, idle, pd, osc, t2, pwm, adc, pull, pull_oe, irst;
   logic ale_o, program_store_strobe_o, keep;
   int bad_count = 0;
   int samples_checked = 0;
   int n;
   always #10 ref_clk_in = ~ref_clk_in;
   power_control_and_reset #(.OSC_DIV(DIV)) i_power_control_and_reset (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .reset_pin_in(reset_pin_in), .watchdog_enable_n_in(ew),
      .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr),
      .sfr_bit_op_in(bop), .serial_mode_in(mode),
      .wdt_load_req_in(ldreq), .wdt_overflow_in(ovf),
      .irq_pending_in(irq), .ale_raw_in(ale), .program_store_strobe_raw_in(program_store_strobe),
      .sfr_rdata_out(rdata), .baud_x2_out(baud), .wdt_load_out(ld),
      .idle_out(idle), .powerdown_out(pd), .osc_run_out(osc),
      .timer2_reset_out(t2), .pwm_force_high_out(pwm),
      .adc_abort_out(adc), .reset_pin_pull_out(pull),
      .reset_pin_pull_oe_out(pull_oe), .internal_reset_out(irst),
      .address_latch_strobe_out(ale_o), .program_store_strobe_out(program_store_strobe_o),
      .port_reset_value_out(portv), .stack_ptr_reset_out(spv),
      .set_enable_reset_out(stev));
   reset_source i_reset_source (.pull_in(pull), .pull_oe_in(pull_oe),
      .pin_out(reset_pin_in));
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task end_sim;
      if (bad_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d, input logic b);
      @(negedge ref_clk_in);
      addr = a; wdata = d; wr = 1'b1; bop = b;
      @(negedge ref_clk_in);
      wr = 1'b0; bop = 1'b0;
   endtask
   task rd(input logic [7:0] exp);
      @(negedge ref_clk_in);
      chk(rdata, exp);
   endtask
   // Bounded wait for the sequencer to let go of reset
   task wait_clear;
      n = 0;
      while (irst !== 1'b0 && n < 200)
      begin
         @(negedge ref_clk_in);
         n++;
      end
      chk({7'h00, irst}, 8'h00);
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task t_power_on;
      repeat (5) @(negedge ref_clk_in);
      chk({6'h00, ale_o, program_store_strobe_o}, 8'h03);
      chk(portv, 8'hFF);
      chk(spv, 8'h07);
      chk(stev, 8'hC0);
      sys_rst_in = 1'b0;
      wait_clear();
      rd(8'h00);
   endtask
   task t_fields;
      wr_reg(A, 8'hFC, 1'b0);
      rd(8'hBC);
      for (int m = 0; m < 4; m++)
      begin
         @(negedge ref_clk_in);
         mode = m[1:0];
         #1 chk({7'h00, baud}, {7'h00, m != 0});
      end
      @(negedge ref_clk_in);
      keep = ale_o;
      ale = ~ale;
      #1 chk({7'h00, ale_o}, {7'h00, keep});
      @(negedge ref_clk_in);
      ldreq = 1'b1;
      #1 chk({7'h00, ld}, 8'h01);
      @(negedge ref_clk_in);
      ldreq = 1'b0;
      rd(8'hAC);
      ldreq = 1'b1;
      #1 chk({7'h00, ld}, 8'h00);
      @(negedge ref_clk_in);
      ldreq = 1'b0;
   endtask
   task t_pin_reset;
      i_reset_source.drive(1'b1);
      repeat (HOLD) @(negedge ref_clk_in);
      chk({5'h00, irst, ale_o, program_store_strobe_o}, 8'h07);
      rd(8'h00);
      i_reset_source.drive(1'b0);
      wait_clear();
   endtask
   task t_byte_only;
      wr_reg(A, 8'h04, 1'b1);
      rd(8'h00);
      wr_reg(8'h88, 8'h04, 1'b0);
      rd(8'h00);
   endtask
   task t_idle;
      wr_reg(A, 8'h01, 1'b0);
      chk({4'h0, idle, t2, pwm, adc}, 8'h0F);
      chk({6'h00, ale_o, program_store_strobe_o}, 8'h03);
      irq = 1'b1;
      @(negedge ref_clk_in);
      irq = 1'b0;
      chk({7'h00, idle}, 8'h00);
      rd(8'h00);
   endtask
   task t_powerdown;
      ew = 1'b0;
      wr_reg(A, 8'h02, 1'b0);
      chk({7'h00, pd}, 8'h00);
      ew = 1'b1;
      wr_reg(A, 8'h03, 1'b0);
      chk({5'h00, pd, idle, osc}, 8'h04);
      chk({6'h00, ale_o, program_store_strobe_o}, 8'h00);
      i_reset_source.drive(1'b1);
      repeat (HOLD) @(negedge ref_clk_in);
      chk({6'h00, irst, pd}, 8'h02);
      i_reset_source.drive(1'b0);
      wait_clear();
   endtask
   task t_watchdog;
      keep = 1'b0;
      @(negedge ref_clk_in);
      ovf = 1'b1;
      @(negedge ref_clk_in);
      ovf = 1'b0;
      n = 0;
      for (int i = 0; i < 40; i++)
      begin
         if (pull_oe === 1'b1 && pull === 1'b1)
            n++;
         if (irst === 1'b1)
            keep = 1'b1;
         @(negedge ref_clk_in);
      end
      chk(n[7:0], 8'(pwr_rst_pkg::WDT_PULSE_MC * DIV));
      chk({7'h00, keep}, 8'h01);
      wait_clear();
   endtask
   // ------------------------------
   // Sequence
   // ------------------------------
   initial
   begin
      t_power_on();
      t_fields();
      t_pin_reset();
      t_byte_only();
      t_idle();
      t_powerdown();
      t_watchdog();
      end_sim();
   end
   // Generous span against a hung sequencer
   initial
   begin
      #200000;
      bad_count++;
      end_sim();
   end
endmodule // tb
